// >>> fsd_pkg.sv
// Contract
// - offset clock is crystal divided by 4/8/16
// - 7-bit gain limits, defaults 27 and 76
// - above upper lowers gain, below lower raises
// - readback strength code, power from correction
// - readback gain codes and correction table
// - select 01 correlator, 00 linear demodulator
// - two correlators, compare their output levels
// - 10-bit correlator bandwidth setting
// - second-order low-pass before the slicer
// - 10-bit post-filter setting sets cutoff
// - correlator slicer threshold fixed at zero
// - clock recovery oversamples at 32x data rate
// - linear: averaging plus envelope, then threshold
// - linear slicer feeds same clock recovery
// - linear uses same post-filter setting
// - sync word match raises interrupt pin
// - interrupt drops nine data clocks later
// - detection only in demod mode 2 or 3
// - sync length 12, 16, 20 or 24 bits
// - tolerate up to three mismatching bits
package fsd_pkg;
    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam logic [3:0] MATCH_HOLD_BITS = 4'h9;
    localparam logic [4:0] CDR_MID_PHASE = 5'h10;
    localparam logic [2:0] GAIN_IDX_MAX = 3'h5;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_AGC = 8'h04;
    localparam logic [7:0] OFS_BW = 8'h08;
    localparam logic [7:0] OFS_SYNC = 8'h0C;
    localparam logic [7:0] OFS_RATE = 8'h10;
    localparam logic [7:0] OFS_READBACK = 8'h14;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_DIV_LSB = 0;
    localparam int CTRL_DEMOD_SEL_LSB = 2;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_SYNC_LEN_LSB = 7;
    localparam int CTRL_SYNC_TOL_LSB = 9;
    localparam int CTRL_AMP_AUTO_BIT = 11;
    localparam int CTRL_FILT_AUTO_BIT = 12;
    localparam int CTRL_AMP_MAN_LSB = 13;
    localparam int CTRL_FILT_MAN_LSB = 15;
    localparam int AGC_LOW_LSB = 0;
    localparam int AGC_HIGH_LSB = 7;
    localparam int AGC_WAIT_LSB = 14;
    localparam int BW_POST_LSB = 0;
    localparam int BW_CORR_LSB = 16;
    localparam int RB_STRENGTH_LSB = 0;
    localparam int RB_AMP_LSB = 7;
    localparam int RB_FILT_LSB = 9;
    localparam int RB_CORR_LSB = 11;
    // ----------------------------------------
    // reset values and demodulator select codes
    // ----------------------------------------
    localparam logic [6:0] RST_GAIN_LOWER = 7'h1B;
    localparam logic [6:0] RST_GAIN_UPPER = 7'h4C;
    localparam logic [7:0] RST_SETTLE_WAIT = 8'h0A;
    localparam logic [9:0] RST_POSTFILTER_BW = 10'h057;
    localparam logic [9:0] RST_CORR_BW = 10'h009;
    localparam logic [15:0] RST_RATE_INC = 16'h1000;
    localparam logic [1:0] DEMOD_LINEAR = 2'h0;
    localparam logic [1:0] DEMOD_CORR = 2'h1;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } fsd_apb_req_t;
    typedef enum logic {
        MS_IDLE = 1'b0,
        MS_HOLD = 1'b1
    } fsd_match_t;
    typedef struct packed {
        logic [1:0] amp;
        logic [1:0] filt;
    } fsd_gain_t;
endpackage

// >>> fsd_rx_core.sv
`timescale 1ns/1ns
`default_nettype none
module fsd_rx_core (
    // clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // register bus
    input wire fsd_pkg::fsd_apb_req_t APB_REQ_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // limiter and strength inputs from the analog side
    input wire logic I_LIM_I,
    input wire logic Q_LIM_I,
    input wire logic [6:0] STRENGTH_I,
    // front-end control
    output logic OFFSET_CLK_EN_O,
    output fsd_pkg::fsd_gain_t GAIN_O,
    // recovered data toward the host
    output logic RX_BIT_O,
    output logic RX_BIT_CLK_O,
    output logic MATCH_INT_O
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [16:0] ctrl;
        logic [6:0] gain_lower;
        logic [6:0] gain_upper;
        logic [7:0] settle_wait;
        logic [9:0] post_bw;
        logic [9:0] corr_bw;
        logic [23:0] sync_word;
        logic [15:0] rate_inc;
        logic [31:0] rdata;
        logic slverr;
        logic [3:0] div_cnt;
        logic off_en;
        logic [1:0] iq_s1;
        logic [1:0] iq_s2;
        logic [1:0] iq_prev;
        logic [6:0] str_s1;
        logic [6:0] str_s2;
        logic [2:0] gain_idx;
        logic [7:0] agc_cnt;
        logic [9:0] win_cnt;
        logic [10:0] pos_cnt;
        logic [10:0] neg_cnt;
        logic signed [15:0] corr_val;
        logic signed [17:0] y1;
        logic signed [17:0] y2;
        logic signed [17:0] env_hi;
        logic signed [17:0] env_lo;
        logic slice;
        logic slice_prev;
        logic [16:0] nco;
        logic [4:0] phase;
        logic bit_q;
        logic bit_stb;
        logic [23:0] shift;
        fsd_pkg::fsd_match_t mstate;
        logic [3:0] hold_cnt;
    } fsd_state_t;

    fsd_state_t s_q;
    fsd_state_t s_d;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [1:0] quad_pos(input logic [1:0] iq);
        case (iq)
            2'b00: quad_pos = 2'd0;
            2'b01: quad_pos = 2'd1;
            2'b11: quad_pos = 2'd2;
            default: quad_pos = 2'd3;
        endcase
    endfunction

    function automatic logic signed [17:0] lpf_step(input logic signed [17:0] y,
            input logic signed [17:0] x, input logic [9:0] k);
        logic signed [18:0] diff;
        logic signed [29:0] prod;
        diff = 19'(x) - 19'(y);
        prod = 30'(diff) * $signed({20'h0_0000, k});
        lpf_step = y + 18'(prod >>> 10);
    endfunction

    function automatic fsd_pkg::fsd_gain_t gain_pair(input logic [2:0] idx);
        case (idx)
            3'd5: gain_pair = '{amp: 2'b11, filt: 2'b10};
            3'd4: gain_pair = '{amp: 2'b10, filt: 2'b10};
            3'd3: gain_pair = '{amp: 2'b10, filt: 2'b01};
            3'd2: gain_pair = '{amp: 2'b10, filt: 2'b00};
            3'd1: gain_pair = '{amp: 2'b01, filt: 2'b00};
            default: gain_pair = '{amp: 2'b00, filt: 2'b00};
        endcase
    endfunction

    function automatic logic [6:0] gain_corr(input fsd_pkg::fsd_gain_t g);
        case ({g.amp, g.filt})
            4'b1110: gain_corr = 7'd0;
            4'b1010: gain_corr = 7'd17;
            4'b1001: gain_corr = 7'd53;
            4'b1000: gain_corr = 7'd65;
            4'b0100: gain_corr = 7'd90;
            4'b0000: gain_corr = 7'd113;
            default: gain_corr = 7'd0;
        endcase
    endfunction

    function automatic logic [4:0] ones(input logic [23:0] v);
        ones = 5'd0;
        for (int i = 0; i < 24; i++) begin
            ones = ones + 5'(v[i]);
        end
    endfunction

    // ----------------------------------------
    // decoded configuration
    // ----------------------------------------
    logic [1:0] div_sel;
    logic [1:0] demod_sel;
    logic [2:0] demod_mode;
    logic [1:0] sync_len;
    logic [1:0] sync_tol;
    logic auto_gain;
    fsd_pkg::fsd_gain_t gain_now;
    logic [6:0] corr_now;
    logic [3:0] div_last;
    logic [23:0] len_mask;
    logic apb_wr;
    logic apb_setup;

    assign div_sel = s_q.ctrl[fsd_pkg::CTRL_DIV_LSB +: 2];
    assign demod_sel = s_q.ctrl[fsd_pkg::CTRL_DEMOD_SEL_LSB +: 2];
    assign demod_mode = s_q.ctrl[fsd_pkg::CTRL_MODE_LSB +: 3];
    assign sync_len = s_q.ctrl[fsd_pkg::CTRL_SYNC_LEN_LSB +: 2];
    assign sync_tol = s_q.ctrl[fsd_pkg::CTRL_SYNC_TOL_LSB +: 2];
    // the loop runs only when both selectors are auto
    assign auto_gain = s_q.ctrl[fsd_pkg::CTRL_AMP_AUTO_BIT]
        & s_q.ctrl[fsd_pkg::CTRL_FILT_AUTO_BIT];
    assign gain_now = auto_gain ? gain_pair(s_q.gain_idx)
        : fsd_pkg::fsd_gain_t'{amp: s_q.ctrl[fsd_pkg::CTRL_AMP_MAN_LSB +: 2],
            filt: s_q.ctrl[fsd_pkg::CTRL_FILT_MAN_LSB +: 2]};
    assign corr_now = gain_corr(gain_now);
    assign div_last = (div_sel == 2'd0) ? 4'd3 : ((div_sel == 2'd1) ? 4'd7 : 4'd15);
    // compare width
    // ones in the low 12/16/20/24 bits, where the newest bits sit
    assign len_mask = ~(24'hFF_F000 << (4 * sync_len));
    assign apb_setup = APB_REQ_I.psel & ~APB_REQ_I.penable;
    assign apb_wr = APB_REQ_I.psel & APB_REQ_I.penable & APB_REQ_I.pwrite;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [1:0] step;
        logic signed [17:0] x_in;
        logic signed [18:0] thr;
        logic edge_seen;
        logic [23:0] shifted;
        logic [4:0] miss;
        s_d = s_q;
        step = 2'd0;
        x_in = 18'sd0;
        thr = 19'sd0;
        edge_seen = 1'b0;
        shifted = 24'h00_0000;
        miss = 5'd0;

        // register bus: read data latched in setup, write taken in access
        if (apb_setup) begin
            s_d.slverr = 1'b0;
            case (APB_REQ_I.paddr)
                fsd_pkg::OFS_CTRL: s_d.rdata = {15'h0000, s_q.ctrl};
                fsd_pkg::OFS_AGC: s_d.rdata = {10'h000, s_q.settle_wait,
                    s_q.gain_upper, s_q.gain_lower};
                fsd_pkg::OFS_BW: s_d.rdata = {6'h00, s_q.corr_bw, 6'h00, s_q.post_bw};
                fsd_pkg::OFS_SYNC: s_d.rdata = {8'h00, s_q.sync_word};
                fsd_pkg::OFS_RATE: s_d.rdata = {16'h0000, s_q.rate_inc};
                fsd_pkg::OFS_READBACK: s_d.rdata = {14'h0000, corr_now, gain_now.filt,
                    gain_now.amp, s_q.str_s2};
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.slverr = 1'b1;
                end
            endcase
        end
        if (apb_wr) begin
            case (APB_REQ_I.paddr)
                fsd_pkg::OFS_CTRL: s_d.ctrl = APB_REQ_I.pwdata[16:0];
                fsd_pkg::OFS_AGC: begin
                    s_d.gain_lower = APB_REQ_I.pwdata[fsd_pkg::AGC_LOW_LSB +: 7];
                    s_d.gain_upper = APB_REQ_I.pwdata[fsd_pkg::AGC_HIGH_LSB +: 7];
                    s_d.settle_wait = APB_REQ_I.pwdata[fsd_pkg::AGC_WAIT_LSB +: 8];
                end
                fsd_pkg::OFS_BW: begin
                    s_d.post_bw = APB_REQ_I.pwdata[fsd_pkg::BW_POST_LSB +: 10];
                    s_d.corr_bw = APB_REQ_I.pwdata[fsd_pkg::BW_CORR_LSB +: 10];
                end
                fsd_pkg::OFS_SYNC: s_d.sync_word = APB_REQ_I.pwdata[23:0];
                fsd_pkg::OFS_RATE: s_d.rate_inc = APB_REQ_I.pwdata[15:0];
                default: ;
            endcase
        end

        s_d.off_en = 1'b0;
        if (s_q.div_cnt >= div_last) begin
            s_d.div_cnt = 4'd0;
            s_d.off_en = 1'b1;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 4'd1;
        end

        // pin synchronisers
        s_d.iq_s1 = {I_LIM_I, Q_LIM_I};
        s_d.iq_s2 = s_q.iq_s1;
        s_d.str_s1 = STRENGTH_I;
        s_d.str_s2 = s_q.str_s1;

        // gain loop, one step then wait to settle
        if (auto_gain && s_q.off_en) begin
            if (s_q.agc_cnt != 8'd0) begin
                s_d.agc_cnt = s_q.agc_cnt - 8'd1;
            end else if (s_q.str_s2 > s_q.gain_upper && s_q.gain_idx != 3'd0) begin
                s_d.gain_idx = s_q.gain_idx - 3'd1;
                s_d.agc_cnt = s_q.settle_wait;
            end else if (s_q.str_s2 < s_q.gain_lower
                    && s_q.gain_idx != fsd_pkg::GAIN_IDX_MAX) begin
                s_d.gain_idx = s_q.gain_idx + 3'd1;
                s_d.agc_cnt = s_q.settle_wait;
            end
        end

        // quadrature rotation direction is the raw frequency sign
        s_d.iq_prev = s_q.iq_s2;
        step = quad_pos(s_q.iq_s2) - quad_pos(s_q.iq_prev);
        // upper and lower tone correlators over the window
        if (step == 2'd1) begin
            s_d.pos_cnt = s_q.pos_cnt + 11'd1;
        end else if (step == 2'd3) begin
            s_d.neg_cnt = s_q.neg_cnt + 11'd1;
        end
        if (s_q.win_cnt == 10'd0) begin
            s_d.win_cnt = s_q.corr_bw;
            s_d.corr_val = 16'($signed({5'h00, s_q.pos_cnt}) - $signed({5'h00, s_q.neg_cnt}));
            s_d.pos_cnt = 11'd0;
            s_d.neg_cnt = 11'd0;
        end else begin
            s_d.win_cnt = s_q.win_cnt - 10'd1;
        end

        if (demod_sel == fsd_pkg::DEMOD_CORR) begin
            x_in = 18'(s_q.corr_val) <<< 4;
        end else begin
            x_in = (step == 2'd1) ? 18'sd256 : ((step == 2'd3) ? -18'sd256 : 18'sd0);
        end
        s_d.y1 = lpf_step(s_q.y1, x_in, s_q.post_bw);
        s_d.y2 = lpf_step(s_q.y2, s_q.y1, s_q.post_bw);

        // envelope with slow decay toward the centre
        // decay once per bit: faster decay collapses the threshold on long runs
        if (s_q.y2 > s_q.env_hi) begin
            s_d.env_hi = s_q.y2;
        end else if (s_q.bit_stb && s_q.env_hi > s_q.env_lo) begin
            s_d.env_hi = s_q.env_hi - 18'sd1;
        end
        if (s_q.y2 < s_q.env_lo) begin
            s_d.env_lo = s_q.y2;
        end else if (s_q.bit_stb && s_q.env_lo < s_q.env_hi) begin
            s_d.env_lo = s_q.env_lo + 18'sd1;
        end
        thr = (19'(s_q.env_hi) + 19'(s_q.env_lo)) >>> 1;
        if (demod_sel == fsd_pkg::DEMOD_CORR) begin
            s_d.slice = s_q.y2 > 18'sd0;
        end else begin
            s_d.slice = 19'(s_q.y2) > thr;
        end

        // oversample enable at 32x the bit rate
        s_d.bit_stb = 1'b0;
        s_d.nco = {1'b0, s_q.nco[15:0]} + {1'b0, s_q.rate_inc};
        if (s_q.nco[16]) begin
            s_d.slice_prev = s_q.slice;
            edge_seen = s_q.slice != s_q.slice_prev;
            // edges late in the bit pull the phase forward by one extra
            if (edge_seen && s_q.phase >= fsd_pkg::CDR_MID_PHASE) begin
                s_d.phase = s_q.phase + 5'd2;
            end else if (edge_seen && s_q.phase != 5'd0) begin
                s_d.phase = s_q.phase;
            end else begin
                s_d.phase = s_q.phase + 5'd1;
            end
            if (s_q.phase == fsd_pkg::CDR_MID_PHASE) begin
                s_d.bit_q = s_q.slice;
                s_d.bit_stb = 1'b1;
            end
        end

        // shift newest bit in, count mismatches
        // first bit received lands at the top
        if (s_q.bit_stb) begin
            shifted = {s_q.shift[22:0], s_q.bit_q};
            s_d.shift = shifted;
            miss = ones((shifted ^ s_q.sync_word) & len_mask);
        end
        case (s_q.mstate)
            fsd_pkg::MS_IDLE: begin
                if (s_q.bit_stb && demod_mode[2:1] == 2'b01 && miss <= {3'd0, sync_tol}) begin
                    s_d.mstate = fsd_pkg::MS_HOLD;
                    s_d.hold_cnt = 4'd0;
                end
            end
            fsd_pkg::MS_HOLD: begin
                if (s_q.bit_stb) begin
                    s_d.hold_cnt = s_q.hold_cnt + 4'd1;
                    if (s_q.hold_cnt + 4'd1 == fsd_pkg::MATCH_HOLD_BITS) begin
                        s_d.mstate = fsd_pkg::MS_IDLE;
                    end
                end
            end
            default: s_d.mstate = fsd_pkg::MS_IDLE;
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            s_q <= '0;
            s_q.gain_lower <= fsd_pkg::RST_GAIN_LOWER;
            s_q.gain_upper <= fsd_pkg::RST_GAIN_UPPER;
            s_q.settle_wait <= fsd_pkg::RST_SETTLE_WAIT;
            s_q.post_bw <= fsd_pkg::RST_POSTFILTER_BW;
            s_q.corr_bw <= fsd_pkg::RST_CORR_BW;
            s_q.rate_inc <= fsd_pkg::RST_RATE_INC;
            s_q.gain_idx <= fsd_pkg::GAIN_IDX_MAX;
            s_q.mstate <= fsd_pkg::MS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA_O = s_q.rdata;
    assign PSLVERR_O = s_q.slverr & APB_REQ_I.psel & APB_REQ_I.penable;
    assign PREADY_O = APB_REQ_I.psel & APB_REQ_I.penable;
    assign OFFSET_CLK_EN_O = s_q.off_en;
    assign GAIN_O = gain_now;
    assign RX_BIT_O = s_q.bit_q;
    assign RX_BIT_CLK_O = s_q.phase[4];
    assign MATCH_INT_O = s_q.mstate == fsd_pkg::MS_HOLD;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    property p_div4;
        OFFSET_CLK_EN_O && div_sel == 2'd0 ##1 (div_sel == 2'd0) [*3]
            |=> OFFSET_CLK_EN_O && !$past(OFFSET_CLK_EN_O)
            && !$past(OFFSET_CLK_EN_O, 2) && !$past(OFFSET_CLK_EN_O, 3);
    endproperty
    a_div4: assert property (p_div4) else $error("offset clock not divided by four");

    property p_limits_reset;
        $fell(SYS_RST_I) |-> s_q.gain_lower == 7'd27 && s_q.gain_upper == 7'd76;
    endproperty
    a_limits_reset: assert property (p_limits_reset) else $error("bad limit defaults");

    property p_gain_down;
        auto_gain && s_q.off_en && s_q.agc_cnt == 8'd0 && s_q.str_s2 > s_q.gain_upper
            && s_q.gain_idx != 3'd0 |=> s_q.gain_idx == $past(s_q.gain_idx) - 3'd1
            && s_q.agc_cnt == $past(s_q.settle_wait);
    endproperty
    a_gain_down: assert property (p_gain_down) else $error("gain not lowered");

    property p_corr_tab;
        {GAIN_O.amp, GAIN_O.filt} == 4'b1001 |-> corr_now == 7'd53;
    endproperty
    a_corr_tab: assert property (p_corr_tab) else $error("wrong gain correction");

    property p_slice_zero;
        demod_sel == fsd_pkg::DEMOD_CORR && s_q.y2 > 18'sd0 |=> s_q.slice;
    endproperty
    a_slice_zero: assert property (p_slice_zero) else $error("slicer not at zero");

    property p_mid_sample;
        s_q.bit_stb |-> $past(s_q.phase) == 5'd16 && $past(s_q.nco[16]);
    endproperty
    a_mid_sample: assert property (p_mid_sample) else $error("bit not sampled mid");

    property p_int_mode;
        $rose(MATCH_INT_O) |-> $past(demod_mode) == 3'd2 || $past(demod_mode) == 3'd3;
    endproperty
    a_int_mode: assert property (p_int_mode) else $error("match outside mode 2/3");

    property p_int_nine;
        MATCH_INT_O && s_q.bit_stb && s_q.hold_cnt == 4'd8 |=> !MATCH_INT_O;
    endproperty
    a_int_nine: assert property (p_int_nine) else $error("pin not dropped at nine");

    property p_sync_wr;
        apb_wr && APB_REQ_I.paddr == fsd_pkg::OFS_SYNC
            |=> s_q.sync_word == $past(APB_REQ_I.pwdata[23:0]);
    endproperty
    a_sync_wr: assert property (p_sync_wr) else $error("sync word write lost");
endmodule
`default_nettype wire

// >>> fsd_tx_model.sv
`timescale 1ns/1ns
`default_nettype none
module fsd_tx_model (
    // clock
    input wire logic clk_i,
    // bit to send
    input wire logic bit_i,
    // limited quadrature pair
    output logic i_o,
    output logic q_o
);
    logic [1:0] div_q = 2'h0;
    logic [1:0] ph_q = 2'h0;
    // ----------------------------------------
    // phasor
    // ----------------------------------------
    // tone above or below centre
    always @(posedge clk_i) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3) begin
            ph_q <= bit_i ? ph_q + 2'h1 : ph_q - 2'h1;
        end
    end
    assign i_o = ph_q[1];
    assign q_o = ph_q[1] ^ ph_q[0];
endmodule
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    fsd_pkg::fsd_apb_req_t req = '0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, err, i_lim, q_lim, off_en, rx_bit, rx_clk, match;
    logic tx_bit = 1'b0;
    logic [6:0] strength = 7'h00;
    fsd_pkg::fsd_gain_t gain;
    int failures = 0;
    int checks = 0;
`define CMP(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
    always #25 clk = ~clk;
    fsd_rx_core fsd_rx_core_i (.CLK_I(clk), .SYS_RST_I(rst), .APB_REQ_I(req),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .I_LIM_I(i_lim),
        .Q_LIM_I(q_lim), .STRENGTH_I(strength), .OFFSET_CLK_EN_O(off_en), .GAIN_O(gain),
        .RX_BIT_O(rx_bit), .RX_BIT_CLK_O(rx_clk), .MATCH_INT_O(match));
    fsd_tx_model fsd_tx_model_i (.clk_i(clk), .bit_i(tx_bit), .i_o(i_lim), .q_o(q_lim));
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) failures++;
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask
    task automatic t_regs();
        apb(1'b0, fsd_pkg::OFS_AGC, 32'h0);
        `CMP(rd[6:0], 7'h1B)
        `CMP(rd[13:7], 7'h4C)
        `CMP(rd[21:14], 8'h0A)
        apb(1'b0, 8'h40, 32'h0);
        `CMP(err, 1'b1)
        `CMP(rd, 32'h0000_0000)
        $display("t_regs done");
    endtask
    task automatic t_div();
        int n;
        for (int d = 0; d < 3; d++) begin
            apb(1'b1, fsd_pkg::OFS_CTRL, 32'(d));
            repeat (20) @(posedge clk);
            while (off_en !== 1'b1) @(posedge clk);
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (off_en !== 1'b1 && n < 40);
            `CMP(n, 4 << d)
        end
        $display("t_div done");
    endtask
    task automatic t_gain();
        logic [10:0] tbl [6] = '{{4'b1110, 7'd0}, {4'b1010, 7'd17}, {4'b1001, 7'd53},
            {4'b1000, 7'd65}, {4'b0100, 7'd90}, {4'b0000, 7'd113}};
        strength <= 7'h2A;
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, fsd_pkg::OFS_CTRL, {15'h0, tbl[i][8:7], tbl[i][10:9], 13'h0});
            apb(1'b0, fsd_pkg::OFS_READBACK, 32'h0);
            `CMP(gain, tbl[i][10:7])
            `CMP(rd[6:0], 7'h2A)
            `CMP(rd[10:7], {tbl[i][8:7], tbl[i][10:9]})
            `CMP(rd[17:11], tbl[i][6:0])
        end
        apb(1'b1, fsd_pkg::OFS_CTRL, 32'h0000_1800);
        // limits stay at 27 and 76, 49 apart
        strength <= 7'h64;
        repeat (600) @(posedge clk);
        `CMP(gain, 4'b0000)
        strength <= 7'h0A;
        repeat (600) @(posedge clk);
        `CMP(gain, 4'b1110)
        $display("t_gain done");
    endtask
    task automatic t_sync(input logic [1:0] sel, input logic [2:0] mode, input int hit);
        logic [23:0] w;
        logic [23:0] got;
        int seen, edges;
        logic pc;
        logic pm;
        // one flipped bit, inside a tolerance of one
        w = 24'h3B_5AC6 ^ 24'h00_0100;
        // window of 64 clocks keeps the correlator level well above rounding
        apb(1'b1, fsd_pkg::OFS_BW, 32'h003F_0057);
        apb(1'b1, fsd_pkg::OFS_SYNC, 32'h003B_5AC6);
        apb(1'b1, fsd_pkg::OFS_CTRL, 32'h0000_0380 | (32'(mode) << 4) | (32'(sel) << 2));
        seen = 0;
        edges = 0;
        pc = 1'b0;
        pm = 1'b0;
        got = 24'h00_0000;
        for (int b = 0; b < 49; b++) begin
            // sync word goes out first bit high
            tx_bit <= (b >= 12 && b < 36) ? w[35 - b] : b[0];
            for (int c = 0; c < 512; c++) begin
                @(posedge clk);
                if (match === 1'b1 && b >= 36) begin
                    seen = 1;
                    if (rx_clk === 1'b1 && pc === 1'b0) edges++;
                end
                if (match === 1'b1 && pm === 1'b0) `CMP({got[22:0], rx_bit}, w)
                if (rx_clk === 1'b0 && pc === 1'b1) got = {got[22:0], rx_bit};
                pc = rx_clk;
                pm = match;
            end
        end
        `CMP(seen, hit)
        if (hit == 1) `CMP(edges, 9)
        $display("t_sync done");
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_div();
        t_gain();
        t_sync(2'b01, 3'h2, 1);
        t_sync(2'b00, 3'h3, 1);
        t_sync(2'b01, 3'h0, 0);
        stop_test();
    end
    initial begin
        repeat (95000) @(posedge clk);
        failures++;
        stop_test();
    end
`undef CMP
endmodule
`default_nettype wire
